// ---- dv/clu_far_side.sv ----
// Purpose: Model of pins, event lines, comparator and timers feeding the unit
// Assumes: Sources are asynchronous to the unit clock
// Notes: Bundle order is pins, events, comparator, timers
`timescale 1ns/10ps
module clu_far_side
(
    input wire logic i_sys_clk,
    input wire logic [11:0] i_drive,
    output logic [5:0] o_table_input_pins,
    output logic [1:0] o_event_router,
    output logic o_comparator,
    output logic [2:0] o_timer_waveform
);
    logic [11:0] lines = 12'h000;
    // Lines move 3 ns after each rising edge so the unit's synchronisers see a true async source
    always @(posedge i_sys_clk)
    begin
        lines <= #3 i_drive;
    end
    assign {o_table_input_pins, o_event_router, o_comparator, o_timer_waveform} = lines;
endmodule

// ---- dv/clu_top_assertions.sv ----
// Purpose: Port-level checks for the custom logic unit
// Assumes: One clock domain, async active-low reset
// Notes: Bound to clu_top from the bench top file
`timescale 1ns/10ps
module clu_top_assertions
(
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_global_control_we,
    input wire logic i_global_control_enable,
    input wire logic [1:0] i_table_control_first_we,
    input wire logic [1:0] i_table_enable,
    input wire logic [1:0] o_table_output_pin,
    input wire logic [1:0] o_event_router,
    input wire logic o_global_enable,
    input wire logic [1:0] o_table_enable
);
    // ********************
    // Checks
    // ********************
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    // Filter and edge logic may need a cycle to clear, hence three cycles
    sequence s_global_off;
        !o_global_enable [*3];
    endsequence
    sequence s_t0_off;
        !o_table_enable[0] [*3];
    endsequence
    sequence s_t1_off;
        !o_table_enable[1] [*3];
    endsequence
    a_global_load: assert property (i_global_control_we |=>
        o_global_enable == $past(i_global_control_enable))
        else $error("global enable not loaded");
    a_global_hold: assert property (!i_global_control_we |=> $stable(o_global_enable))
        else $error("global enable moved without a write");
    a_table0_load: assert property (i_table_control_first_we[0] |=>
        o_table_enable[0] == $past(i_table_enable[0]))
        else $error("table 0 enable not loaded");
    a_table1_load: assert property (i_table_control_first_we[1] |=>
        o_table_enable[1] == $past(i_table_enable[1]))
        else $error("table 1 enable not loaded");
    a_table_hold: assert property (i_table_control_first_we == 2'b00 |=>
        $stable(o_table_enable))
        else $error("table enable moved without a write");
    a_global_low: assert property (s_global_off |-> o_table_output_pin == 2'b00)
        else $error("output high while unit disabled");
    a_table0_low: assert property (s_t0_off |-> !o_table_output_pin[0])
        else $error("table 0 output high while disabled");
    a_table1_low: assert property (s_t1_off |-> !o_table_output_pin[1])
        else $error("table 1 output high while disabled");
    a_event_mirror: assert property (o_event_router == o_table_output_pin)
        else $error("event output differs from pin output");
endmodule

// ---- dv/clu_top_tb.sv ----
// Purpose: Self-checking bench for the custom logic unit
// Assumes: Filter and edge stages off except in the final table 1 checks, sources synced in two flops
// Notes: Table rows drive table 0; awkward cases follow by hand
`timescale 1ns/10ps
module clu_top_tb;
    import clu_pkg::*;
    typedef struct packed {
        logic [7:0] truth;
        logic [3:0] s0;
        logic [3:0] s1;
        logic [3:0] s2;
        logic [11:0] far;
        logic exp;
    } clu_row_t;
    clu_row_t rows [12] = '{
        '{8'h80, 4'h5, 4'h5, 4'h5, 12'h1c0, 1'b1}, '{8'h80, 4'h5, 4'h5, 4'h5, 12'h0c0, 1'b0},
        '{8'h10, 4'h5, 4'h5, 4'h5, 12'h100, 1'b1}, '{8'h02, 4'h5, 4'h5, 4'h5, 12'h040, 1'b1},
        '{8'h02, 4'h5, 4'h5, 4'h5, 12'h100, 1'b0}, '{8'hfe, 4'h0, 4'h0, 4'h0, 12'h1c0, 1'b0},
        '{8'h02, 4'h6, 4'h0, 4'h0, 12'h008, 1'b1}, '{8'h02, 4'h7, 4'h0, 4'h0, 12'h001, 1'b1},
        '{8'h02, 4'h9, 4'h0, 4'h0, 12'h004, 1'b1}, '{8'h02, 4'h3, 4'h0, 4'h0, 12'h010, 1'b1},
        '{8'h04, 4'h0, 4'h4, 4'h0, 12'h020, 1'b1}, '{8'h02, 4'h8, 4'h0, 4'h0, 12'h005, 1'b0}};
    logic i_sys_clk = 1'b0, i_reset_n = 1'b0, i_global_control_we = 1'b0;
    logic i_global_control_enable = 1'b0, i_sequential_control_we = 1'b0;
    logic [1:0] i_table_control_first_we = '0, i_table_enable = '0, i_clock_source_select = '0;
    logic [1:0] i_filter_select = '0, i_edge_detect_enable = '0, i_table_control_second_we = '0;
    logic [1:0] i_table_control_third_we = '0, i_truth_we = '0, i_sequential_function_select = '0;
    logic [3:0] i_input0_source_select = '0, i_input1_source_select = '0;
    logic [3:0] i_input2_source_select = '0;
    logic [7:0] i_truth_table_bits = '0;
    logic [11:0] far_drive = '0;
    wire logic [5:0] i_table_input_pins;
    wire logic [1:0] i_event_router;
    wire logic i_comparator;
    wire logic [2:0] i_timer_waveform;
    wire logic [1:0] o_table_output_pin, o_event_router, o_table_enable;
    wire logic o_global_enable;
    int fails = 0;
    int compares = 0;
    clu_far_side far (.i_sys_clk, .i_drive(far_drive), .o_table_input_pins(i_table_input_pins),
        .o_event_router(i_event_router), .o_comparator(i_comparator),
        .o_timer_waveform(i_timer_waveform));
    clu_top dut (.i_sys_clk, .i_reset_n, .i_global_control_we, .i_global_control_enable,
        .i_table_control_first_we, .i_table_enable, .i_clock_source_select, .i_filter_select,
        .i_edge_detect_enable, .i_table_control_second_we, .i_input0_source_select,
        .i_input1_source_select, .i_table_control_third_we, .i_input2_source_select,
        .i_truth_we, .i_truth_table_bits, .i_sequential_control_we,
        .i_sequential_function_select, .i_table_input_pins, .i_event_router, .i_comparator,
        .i_timer_waveform, .o_table_output_pin, .o_event_router, .o_global_enable,
        .o_table_enable);
    // ********************
    // Drivers and compares
    // ********************
    task automatic wr_glob(input logic en);
        @(posedge i_sys_clk);
        #1;
        i_global_control_we = 1'b1;
        i_global_control_enable = en;
        @(posedge i_sys_clk);
        #1;
        i_global_control_we = 1'b0;
    endtask
    task automatic wr_first(input int t, input logic en, input logic cs);
        @(posedge i_sys_clk);
        #1;
        i_table_control_first_we[t] = 1'b1;
        i_table_enable[t] = en;
        i_clock_source_select[t] = cs;
        @(posedge i_sys_clk);
        #1;
        i_table_control_first_we = 2'b00;
    endtask
    task automatic wr_cfg(input int t, input logic [7:0] tt, input logic [3:0] a,
        input logic [3:0] b, input logic [3:0] c);
        @(posedge i_sys_clk);
        #1;
        i_truth_we[t] = 1'b1;
        i_table_control_second_we[t] = 1'b1;
        i_table_control_third_we[t] = 1'b1;
        i_truth_table_bits = tt;
        i_input0_source_select = a;
        i_input1_source_select = b;
        i_input2_source_select = c;
        @(posedge i_sys_clk);
        #1;
        i_truth_we = 2'b00;
        i_table_control_second_we = 2'b00;
        i_table_control_third_we = 2'b00;
    endtask
    task automatic wr_seq(input logic [1:0] s);
        @(posedge i_sys_clk);
        #1;
        i_sequential_control_we = 1'b1;
        i_sequential_function_select = s;
        @(posedge i_sys_clk);
        #1;
        i_sequential_control_we = 1'b0;
    endtask
    task automatic compare_out(input logic [1:0] exp, input int waits = 6);
        repeat (waits) @(posedge i_sys_clk);
        #1;
        compares++;
        if (o_table_output_pin !== exp || o_event_router !== exp)
        begin
            fails++;
            $display("mismatch at %0t: output %b expected %b", $time, o_table_output_pin, exp);
        end
    endtask
    task automatic compare_en(input logic g, input logic [1:0] t);
        compares++;
        if (o_global_enable !== g || o_table_enable !== t)
        begin
            fails++;
            $display("mismatch at %0t: enables %b%b", $time, o_global_enable, o_table_enable);
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ********************
    // Sequence
    // ********************
    initial
    begin
        forever #10 i_sys_clk = ~i_sys_clk;
    end
    initial
    begin
        repeat (5000) @(posedge i_sys_clk);
        fails++;
        report_and_stop();
    end
    initial
    begin
        repeat (2) @(posedge i_sys_clk);
        #1;
        i_reset_n = 1'b1;
        compare_out(2'b00);
        wr_glob(1'b1);
        compare_en(1'b1, 2'b00);
        foreach (rows[k])
        begin
            wr_first(0, 1'b0, 1'b0);
            wr_cfg(0, rows[k].truth, rows[k].s0, rows[k].s1, rows[k].s2);
            wr_first(0, 1'b1, 1'b0);
            far_drive = rows[k].far;
            compare_out({1'b0, rows[k].exp});
        end
        wr_first(0, 1'b0, 1'b0);
        wr_cfg(0, 8'h80, 4'h5, 4'h5, 4'h5);
        wr_first(0, 1'b1, 1'b0);
        far_drive = 12'h1c0;
        compare_out(2'b01);
        wr_cfg(0, 8'h00, 4'h0, 4'h0, 4'h0);
        compare_out(2'b01);
        wr_glob(1'b0);
        compare_out(2'b00);
        wr_first(0, 1'b0, 1'b0);
        wr_cfg(0, 8'h08, 4'h5, 4'h5, 4'h5);
        wr_first(0, 1'b1, 1'b1);
        wr_glob(1'b1);
        compare_out(2'b01);
        wr_glob(1'b0);
        wr_first(0, 1'b0, 1'b0);
        compare_en(1'b0, 2'b00);
        wr_cfg(1, 8'hff, 4'h0, 4'h0, 4'h0);
        wr_first(1, 1'b1, 1'b0);
        wr_cfg(0, 8'h02, 4'h2, 4'h0, 4'h0);
        wr_first(0, 1'b1, 1'b0);
        wr_glob(1'b1);
        compare_out(2'b11);
        wr_first(0, 1'b0, 1'b0);
        compare_out(2'b10);
        compare_en(1'b1, 2'b10);
        // JK pair: J is feedback or pin 1, K is pin 3
        wr_first(1, 1'b0, 1'b0);
        wr_cfg(1, 8'h02, 4'h5, 4'h0, 4'h0);
        wr_cfg(0, 8'h0e, 4'h1, 4'h5, 4'h0);
        wr_seq(2'h1);
        far_drive = 12'h080;
        wr_first(1, 1'b1, 1'b0);
        wr_first(0, 1'b1, 1'b0);
        compare_out(2'b01);
        wr_seq(2'h3);
        far_drive = 12'h000;
        compare_out(2'b01);
        far_drive = 12'h200;
        compare_out(2'b10);
        far_drive = 12'h080;
        compare_out(2'b01);
        far_drive = 12'h000;
        wr_first(0, 1'b0, 1'b0);
        wr_first(0, 1'b1, 1'b0);
        compare_out(2'b00);
        // Filter, then edge detector, on table 1
        far_drive = 12'h200;
        wr_first(1, 1'b0, 1'b0);
        i_filter_select = 2'h2;
        wr_first(1, 1'b1, 1'b0);
        compare_out(2'b00, 0);
        compare_out(2'b10);
        wr_first(1, 1'b0, 1'b0);
        i_edge_detect_enable = 2'b10;
        wr_first(1, 1'b1, 1'b0);
        compare_out(2'b00);
        i_reset_n = 1'b0;
        compare_out(2'b00);
        compare_en(1'b0, 2'b00);
        i_reset_n = 1'b1;
        report_and_stop();
    end
endmodule
bind clu_top clu_top_assertions u_chk (.i_sys_clk, .i_reset_n, .i_global_control_we,
    .i_global_control_enable, .i_table_control_first_we, .i_table_enable,
    .o_table_output_pin, .o_event_router, .o_global_enable, .o_table_enable);

// ---- src/clu_out_stage.sv ----
// Purpose: Per-table output stage: synchroniser, filter, edge detector
// Assumes: Clock is the table's selected clock
// Notes: Filter stages clear while the table is disabled
`timescale 1ns/10ps
module clu_out_stage
    import clu_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_enable,
    input wire logic i_lut,
    input wire logic [1:0] i_filter_select,
    input wire logic i_edge_detect_enable,
    output logic o_out
);
    import clu_pkg::*;

    logic [3:0] stage;
    logic edge_last;
    logic filt_out;
    wire logic sync_out = stage[1];
    // Majority of the last three taps rejects single-cycle spikes
    wire logic maj = (stage[1] & stage[2]) | (stage[1] & stage[3]) | (stage[2] & stage[3]);
    wire logic filt_sel = (i_filter_select == CLU_FILT_FILTER);
    wire logic sync_sel = (i_filter_select == CLU_FILT_SYNC);
    wire logic level = filt_sel ? filt_out : (sync_sel ? sync_out : i_lut);
    wire logic edge_out = level & ~edge_last;

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            stage <= 4'h0;
            filt_out <= 1'b0;
            edge_last <= 1'b0;
        end
        else if (!i_enable)
        begin
            stage <= 4'h0;
            filt_out <= 1'b0;
            edge_last <= 1'b0;
        end
        else
        begin
            stage <= {stage[2:0], i_lut};
            filt_out <= maj;
            edge_last <= level;
        end
    end

    assign o_out = i_enable & (i_edge_detect_enable ? edge_out : level);
endmodule

// ---- src/clu_pkg.sv ----
// Purpose: Shared constants and types for the custom logic unit
// Assumes: Two tables, one sequential element, 50 MHz peripheral clock
// Notes: Source-select and mode encodings are local choices
package clu_pkg;
    localparam int CLU_TABLES = 2;
    localparam int CLU_IN_W = 3;
    localparam int CLU_SRC_W = 4;
    localparam int CLU_TRUTH_W = 8;
    localparam int CLU_FILT_W = 2;
    localparam int CLU_PERIPH_W = 3;
    localparam int CLU_EVENT_W = 2;
    localparam int CLU_CLK_PERIOD_NS = 20;
    localparam logic [7:0] CLU_TRUTH_RESET = 8'h00;
    localparam logic [3:0] CLU_SRC_RESET = 4'h0;
    localparam logic [1:0] CLU_FILT_RESET = 2'h0;
    localparam logic [1:0] CLU_SEQ_RESET = 2'h0;

    typedef enum logic [3:0]
    {
        CLU_SRC_MASK = 4'h0,
        CLU_SRC_FEEDBACK = 4'h1,
        CLU_SRC_LINK = 4'h2,
        CLU_SRC_EVENT0 = 4'h3,
        CLU_SRC_EVENT1 = 4'h4,
        CLU_SRC_PIN = 4'h5,
        CLU_SRC_COMPARATOR = 4'h6,
        CLU_SRC_TIMER0 = 4'h7,
        CLU_SRC_TIMER1 = 4'h8,
        CLU_SRC_TIMER2 = 4'h9
    } clu_src_t;

    typedef enum logic [1:0]
    {
        CLU_FILT_NONE = 2'h0,
        CLU_FILT_SYNC = 2'h1,
        CLU_FILT_FILTER = 2'h2
    } clu_filt_t;

    typedef enum logic [1:0]
    {
        CLU_SEQ_DFF = 2'h0,
        CLU_SEQ_JK = 2'h1,
        CLU_SEQ_DLATCH = 2'h2,
        CLU_SEQ_RS = 2'h3
    } clu_seq_t;
endpackage

// ---- src/clu_seq_elem.sv ----
// Purpose: Sequential element driven by an even/odd table pair
// Assumes: Clock is the even table's selected clock
// Notes: Latch modes are modelled as clocked sampling
`timescale 1ns/10ps
module clu_seq_elem
    import clu_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_even_enable,
    input wire logic [1:0] i_sequential_function_select,
    input wire logic i_even,
    input wire logic i_odd,
    output logic o_out
);
    import clu_pkg::*;

    logic state;
    logic clr_hold;
    logic next_state;
    wire logic clr_n = i_reset_n & i_even_enable;

    always_comb
    begin
        next_state = state;
        unique case (clu_seq_t'(i_sequential_function_select))
            CLU_SEQ_DFF, CLU_SEQ_DLATCH:
            begin
                if (i_odd)
                    next_state = i_even;
            end
            CLU_SEQ_JK:
            begin
                unique case ({i_even, i_odd})
                    2'b00: next_state = state;
                    2'b01: next_state = 1'b0;
                    2'b10: next_state = 1'b1;
                    2'b11: next_state = ~state;
                endcase
            end
            CLU_SEQ_RS:
            begin
                if (i_even & ~i_odd)
                    next_state = 1'b1;
                else if (i_odd & ~i_even)
                    next_state = 1'b0;
            end
        endcase
    end

    // Disabling the even table clears at once and holds clear one more edge
    always_ff @(posedge i_clk or negedge clr_n)
    begin
        if (!clr_n)
        begin
            state <= 1'b0;
            clr_hold <= 1'b1;
        end
        else if (clr_hold)
        begin
            state <= 1'b0;
            clr_hold <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign o_out = state;
endmodule

// ---- src/clu_top.sv ----
// Purpose: Custom logic unit with two look-up tables and one sequential element
// Assumes: Configuration arrives as plain write strobes with data ports
// Notes: Runs on through debug halt; no freeze input exists
`timescale 1ns/10ps
module clu_top
    import clu_pkg::*;
#(
    parameter int TABLES = clu_pkg::CLU_TABLES
)
(
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_global_control_we,
    input wire logic i_global_control_enable,
    input wire logic [1:0] i_table_control_first_we,
    input wire logic [1:0] i_table_enable,
    input wire logic [1:0] i_clock_source_select,
    input wire logic [1:0] i_filter_select,
    input wire logic [1:0] i_edge_detect_enable,
    input wire logic [1:0] i_table_control_second_we,
    input wire logic [clu_pkg::CLU_SRC_W-1:0] i_input0_source_select,
    input wire logic [clu_pkg::CLU_SRC_W-1:0] i_input1_source_select,
    input wire logic [1:0] i_table_control_third_we,
    input wire logic [clu_pkg::CLU_SRC_W-1:0] i_input2_source_select,
    input wire logic [1:0] i_truth_we,
    input wire logic [clu_pkg::CLU_TRUTH_W-1:0] i_truth_table_bits,
    input wire logic i_sequential_control_we,
    input wire logic [1:0] i_sequential_function_select,
    input wire logic [5:0] i_table_input_pins,
    input wire logic [1:0] i_event_router,
    input wire logic i_comparator,
    input wire logic [clu_pkg::CLU_PERIPH_W-1:0] i_timer_waveform,
    output logic [1:0] o_table_output_pin,
    output logic [1:0] o_event_router,
    output logic o_global_enable,
    output logic [1:0] o_table_enable
);
    import clu_pkg::*;

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [5:0] pin_meta;
    logic [5:0] pin_sync;
    logic [1:0] evt_meta;
    logic [1:0] evt_sync;
    logic cmp_meta;
    logic cmp_sync;
    logic [CLU_PERIPH_W-1:0] tmr_meta;
    logic [CLU_PERIPH_W-1:0] tmr_sync;

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            pin_meta <= 6'h00;
            pin_sync <= 6'h00;
            evt_meta <= 2'h0;
            evt_sync <= 2'h0;
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
            tmr_meta <= '0;
            tmr_sync <= '0;
        end
        else
        begin
            pin_meta <= i_table_input_pins;
            pin_sync <= pin_meta;
            evt_meta <= i_event_router;
            evt_sync <= evt_meta;
            cmp_meta <= i_comparator;
            cmp_sync <= cmp_meta;
            tmr_meta <= i_timer_waveform;
            tmr_sync <= tmr_meta;
        end
    end

    // ****************************************
    // Configuration storage
    // ****************************************
    logic global_enable;
    logic [1:0] table_enable;
    logic [1:0] clk_sel;
    logic [1:0] filt_sel [2];
    logic [1:0] edge_en;
    logic [CLU_SRC_W-1:0] src_sel [2][3];
    logic [CLU_TRUTH_W-1:0] truth [2];
    logic [1:0] seq_sel;

    // Protected fields load only when disabled, or when this write enables
    function automatic logic prot_ok(input logic en_now, input logic en_wr, input logic en_new);
        prot_ok = !en_now || (en_wr && en_new);
    endfunction

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            global_enable <= 1'b0;
        else if (i_global_control_we)
            global_enable <= i_global_control_enable;
    end

    wire logic [1:0] cfg_ok_first = {prot_ok(table_enable[1], 1'b1, i_table_enable[1]),
                                     prot_ok(table_enable[0], 1'b1, i_table_enable[0])};
    wire logic [1:0] cfg_ok_other = ~table_enable;
    wire logic seq_ok = !table_enable[0];

    // Write strobes that survive the enable protection
    wire logic [1:0] load_prot = i_table_control_first_we & cfg_ok_first;
    wire logic [1:0] load_src01 = i_table_control_second_we & cfg_ok_other;
    wire logic [1:0] load_src2 = i_table_control_third_we & cfg_ok_other;
    wire logic [1:0] load_truth = i_truth_we & cfg_ok_other;
    wire logic load_seq = i_sequential_control_we & seq_ok;
    // The enable bit itself is never protected
    wire logic [1:0] next_table_enable = (i_table_control_first_we & i_table_enable) |
                                         (~i_table_control_first_we & table_enable);

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            table_enable <= 2'h0;
        else
            table_enable <= next_table_enable;
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            clk_sel <= 2'h0;
            edge_en <= 2'h0;
            filt_sel[0] <= CLU_FILT_RESET;
            filt_sel[1] <= CLU_FILT_RESET;
        end
        else
        begin
            for (int k = 0; k < 2; k++)
            begin
                if (load_prot[k])
                begin
                    clk_sel[k] <= i_clock_source_select[k];
                    filt_sel[k] <= i_filter_select;
                    edge_en[k] <= i_edge_detect_enable[k];
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            for (int k = 0; k < 2; k++)
            begin
                src_sel[k][0] <= CLU_SRC_RESET;
                src_sel[k][1] <= CLU_SRC_RESET;
                src_sel[k][2] <= CLU_SRC_RESET;
            end
        end
        else
        begin
            for (int k = 0; k < 2; k++)
            begin
                if (load_src01[k])
                begin
                    src_sel[k][0] <= i_input0_source_select;
                    src_sel[k][1] <= i_input1_source_select;
                end
                if (load_src2[k])
                    src_sel[k][2] <= i_input2_source_select;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            truth[0] <= CLU_TRUTH_RESET;
            truth[1] <= CLU_TRUTH_RESET;
        end
        else
        begin
            for (int k = 0; k < 2; k++)
            begin
                if (load_truth[k])
                    truth[k] <= i_truth_table_bits;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            seq_sel <= CLU_SEQ_RESET;
        else if (load_seq)
            seq_sel <= i_sequential_function_select;
    end

    // ****************************************
    // Input selection and truth tables
    // ****************************************
    logic seq_out;
    logic [1:0] lut_raw;
    logic [1:0] stage_out;
    logic [1:0] lut_clk;
    logic [2:0] lut_in [2];

    // One source multiplexer shared by all six inputs
    function automatic logic pick(input logic [CLU_SRC_W-1:0] sel, input logic pin,
                                  input logic link, input logic fb, input logic [1:0] evt,
                                  input logic cmp, input logic [CLU_PERIPH_W-1:0] tmr);
        unique case (clu_src_t'(sel))
            CLU_SRC_MASK: pick = 1'b0;
            CLU_SRC_FEEDBACK: pick = fb;
            CLU_SRC_LINK: pick = link;
            CLU_SRC_EVENT0: pick = evt[0];
            CLU_SRC_EVENT1: pick = evt[1];
            CLU_SRC_PIN: pick = pin;
            CLU_SRC_COMPARATOR: pick = cmp;
            CLU_SRC_TIMER0: pick = tmr[0];
            CLU_SRC_TIMER1: pick = tmr[1];
            CLU_SRC_TIMER2: pick = tmr[2];
            default: pick = 1'b0;
        endcase
    endfunction

    wire logic [1:0] link_src = {lut_raw[0], lut_raw[1]};
    wire logic [1:0] table_live = table_enable & {2{global_enable}};

    genvar t;
    generate
        for (t = 0; t < 2; t++)
        begin : g_lut
            genvar i;
            for (i = 0; i < 3; i++)
            begin : g_in
                assign lut_in[t][i] = pick(src_sel[t][i], pin_sync[t*3+i], link_src[t],
                                           seq_out, evt_sync, cmp_sync, tmr_sync);
            end
            // Input 2 is the clock when selected, so it reads as masked
            wire logic [2:0] idx = {lut_in[t][2] & ~clk_sel[t], lut_in[t][1:0]};
            assign lut_raw[t] = table_live[t] & truth[t][idx];
            assign lut_clk[t] = clk_sel[t] ? lut_in[t][2] : i_sys_clk;

            clu_out_stage u_stage
            (
                .i_clk(lut_clk[t]),
                .i_reset_n(i_reset_n),
                .i_enable(table_live[t]),
                .i_lut(lut_raw[t]),
                .i_filter_select(filt_sel[t]),
                .i_edge_detect_enable(edge_en[t]),
                .o_out(stage_out[t])
            );
        end
    endgenerate

    // ****************************************
    // Sequential element and outputs
    // ****************************************
    wire logic seq_active = table_live[0];

    clu_seq_elem u_seq
    (
        .i_clk(lut_clk[0]),
        .i_reset_n(i_reset_n),
        .i_even_enable(seq_active),
        .i_sequential_function_select(seq_sel),
        .i_even(stage_out[0]),
        .i_odd(stage_out[1]),
        .o_out(seq_out)
    );

    // Logic keeps running regardless of any processor halt state
    assign o_table_output_pin = stage_out;
    assign o_event_router = stage_out;
    assign o_global_enable = global_enable;
    assign o_table_enable = table_enable;
endmodule
